// ===== agx_core.sv
// automatic gain control core: stepped gain with attack, hold and release timers
// Contract
// RL1: gain moves by exactly one 0.5 dB step per adjustment
// RL2: near-constant envelope inside the steady window leaves gain unchanged
// RL3: first crossing above limiter cuts gain at once and restarts all timers
// RL4: no further cut while the attack timer is still running, except on a new first crossing above the limiter
// RL5: attack expiry with signal still above limiter cuts one step, restarts timers
// RL6: release expiry with signal below target raises one step, restarts timers
// RL7: select pins pick off, limiter, limiter plus compression, or all plus gate
// RL8: gain stays between fixed gain 6 dB and maximum gain 30 dB
// RL9: attack period 6.4 ms per step, release period 1.81 s per step
// RL10: limiter 9 dBV, gate 20 mV, compression 2:1 are fixed defaults
// RL11: junction above 150 degrees C shuts the amplifier off
// RL12: closed noise gate holds gain and blocks release increases
`timescale 1ns/10ps
module agx_core import agx_pkg::*; #(
	parameter int ATTACK_CYCLES = ATTACK_CYC,
	parameter int RELEASE_CYCLES = RELEASE_CYC,
	parameter int HOLD_CYCLES = HOLD_CYC,
	parameter int TMR_W = 28
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// static function select pins
	input wire logic function_select_high_in,
	input wire logic function_select_low_in,
	// measured input envelope, 0.5 dB codes above the floor
	input wire logic [ENV_W-1:0] envelope_in,
	// junction temperature in degrees C
	input wire logic [TEMP_W-1:0] junction_temp_in,
	// gain stage control
	output logic [GAIN_W-1:0] gain_out,
	output logic shutdown_out,
	// status
	output logic limiting_out,
	output logic gate_closed_out,
	output logic attack_busy_out
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	agx_state_t state;
	agx_state_t next_state;
	agx_mode_t mode;
	agx_mode_t next_mode;
	logic [GAIN_W-1:0] gain;
	logic [GAIN_W-1:0] next_gain;
	logic above_prev;
	logic shutdown;
	logic gate_q;
	logic busy_q;
	logic above_w;
	logic below_w;
	logic gate_w;
	logic running;
	logic hot;
	logic first_rise;
	logic at_floor;
	logic at_ceiling;
	logic step_down;
	logic step_up;
	logic restart_all;
	logic atk_done;
	logic rel_done;
	logic hold_done;
	logic steady;
	logic next_busy;
	logic [TMR_W-1:0] since_restart;

	// ----------------------------------------------------------------
	// function selection
	// ----------------------------------------------------------------
	// pins are static straps; sampling them every cycle costs nothing
	assign next_mode = agx_mode_t'({function_select_high_in, function_select_low_in}); // RL7

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			mode <= MODE_OFF;
		end else begin
			mode <= next_mode;
		end
	end

	// ----------------------------------------------------------------
	// level decisions
	// ----------------------------------------------------------------
	agx_level u_level (
		.env_in(envelope_in),
		.gain_in(gain),
		.mode_in(mode),
		.above_limit_out(above_w),
		.below_target_out(below_w),
		.gate_closed_out(gate_w)
	);

	// ----------------------------------------------------------------
	// control state
	// ----------------------------------------------------------------
	// thermal trip outranks every function set
	assign hot = (junction_temp_in > TEMP_LIMIT_C); // RL11
	assign next_state = hot ? ST_HOT : (mode == MODE_OFF) ? ST_OFF : ST_RUN; // RL7
	assign running = (state == ST_RUN);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// timers
	// ----------------------------------------------------------------
	// release only counts once hold has lapsed, so each release period
	// starts fresh after every gain change
	agx_timer #(.W(TMR_W), .LOAD(ATTACK_CYCLES)) u_attack (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.restart_in(restart_all),
		.run_in(running),
		.expired_out(atk_done)
	);

	agx_timer #(.W(TMR_W), .LOAD(HOLD_CYCLES)) u_hold (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.restart_in(restart_all),
		.run_in(running),
		.expired_out(hold_done)
	);

	agx_timer #(.W(TMR_W), .LOAD(RELEASE_CYCLES)) u_release (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.restart_in(restart_all),
		.run_in(running && hold_done),
		.expired_out(rel_done)
	);

	// ----------------------------------------------------------------
	// step decisions
	// ----------------------------------------------------------------
	// bounds look at the registered gain, so a step never lands outside
	// the range even when a cut and a bound meet in one cycle
	assign at_floor = (gain <= FIXED_GAIN_CODE); // RL8
	assign at_ceiling = (gain >= MAX_GAIN_CODE); // RL8
	assign first_rise = running && above_w && !above_prev; // RL3
	// a cut is allowed on the first crossing, later only when attack ends
	assign step_down = running && above_w && !at_floor && (first_rise || atk_done); // RL4
	assign step_up = running && !above_w && below_w && !gate_w && rel_done
		&& !at_ceiling; // RL6
	assign steady = running && !above_w && !below_w; // RL2
	// timers also restart outside of run so tracking resumes cleanly
	assign restart_all = !running || first_rise || step_down || step_up; // RL5

	// one code per step, never more
	assign next_gain = !running ? FIXED_GAIN_CODE :
		step_down ? gain - GAIN_STEP :
		step_up ? gain + GAIN_STEP : gain; // RL1

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gain <= FIXED_GAIN_CODE;
		end else begin
			gain <= next_gain;
		end
	end

	// ----------------------------------------------------------------
	// registered status
	// ----------------------------------------------------------------
	// busy must already show on the cycle after a cut, so a reload counts
	// as running although the timer status still reads expired
	assign next_busy = running && (restart_all || !atk_done); // RL4

	// above_prev is cleared outside run so re-entry counts as a first rise
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			above_prev <= 1'b0;
			shutdown <= 1'b0;
			gate_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			above_prev <= running && above_w;
			shutdown <= hot; // RL11
			gate_q <= running && gate_w;
			busy_q <= next_busy;
		end
	end

	assign gain_out = gain;
	assign shutdown_out = shutdown;
	assign limiting_out = above_prev;
	assign gate_closed_out = gate_q;
	assign attack_busy_out = busy_q;

	// ----------------------------------------------------------------
	// check helpers
	// ----------------------------------------------------------------
	// cycles since the last timer restart, saturating; only the checks read
	// it, so the long release default costs a counter and no unrolling
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			since_restart <= '0;
		end else if (restart_all) begin
			since_restart <= '0;
		end else if (since_restart != '1) begin
			since_restart <= since_restart + TMR_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_gain_cut;
		##1 gain == $past(gain) - GAIN_STEP;
	endsequence

	sequence s_gain_rise;
		##1 gain == $past(gain) + GAIN_STEP;
	endsequence

	// timers freshly reloaded one cycle later
	sequence s_timers_fresh;
		##1 !atk_done && !hold_done && !rel_done;
	endsequence

	a_step_size: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL1
		running && $past(running) && $changed(gain) |->
			(gain == $past(gain) + GAIN_STEP) || (gain == $past(gain) - GAIN_STEP))
		else $error("gain moved by other than one step");

	a_steady_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL2
		steady && next_state == ST_RUN |=> $stable(gain))
		else $error("gain changed in the steady window");

	a_first_cut: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL3
		first_rise && !at_floor |-> s_gain_cut)
		else $error("first limiter crossing did not cut gain");

	a_first_restart: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL3
		first_rise |=> !atk_done && !hold_done && !rel_done)
		else $error("timers not restarted on first crossing");

	a_attack_block: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL4
		running && above_w && above_prev && !atk_done |=> gain >= $past(gain))
		else $error("gain cut while attack timer running");

	a_attack_cut: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL5
		running && above_w && atk_done && !at_floor |-> s_gain_cut ##0 !atk_done)
		else $error("attack expiry did not cut gain and restart");

	a_release_rise: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL6
		running && rel_done && below_w && !above_w && !gate_w && !at_ceiling
			|-> s_gain_rise ##0 !rel_done)
		else $error("release expiry did not raise gain");

	a_off_fixed: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL7
		mode == MODE_OFF && !hot |-> ##[1:2] gain == FIXED_GAIN_CODE)
		else $error("disabled function set did not hold fixed gain");

	a_gain_bounds: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL8
		gain >= FIXED_GAIN_CODE && gain <= MAX_GAIN_CODE)
		else $error("gain outside fixed and maximum bounds");

	a_thermal_off: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL11
		hot |=> shutdown_out ##1 (gain == FIXED_GAIN_CODE))
		else $error("over temperature did not shut down");

	a_gate_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL12
		running && gate_w && next_state == ST_RUN |=> gain <= $past(gain))
		else $error("gain raised while noise gate closed");

	// the gate flag is a registered copy of last cycle's decision
	a_gate_status: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL12
		gate_closed_out |-> $past(running) && $past(mode) == MODE_GATE
			&& $past(envelope_in) < NGATE_CODE)
		else $error("gate flag set while gate open");

	// a cut must leave the attack timer reloaded and its flag raised
	a_cut_busy: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL4
		step_down |-> s_timers_fresh ##0 attack_busy_out)
		else $error("cut did not reload the attack timer");

	// spacing is measured on the helper counter, which keeps the long
	// release default out of any repetition count
	a_attack_space: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL5
		step_down && !first_rise |-> since_restart >= TMR_W'(ATTACK_CYCLES))
		else $error("gain cut before the attack period ended");

	a_release_wait: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL6
		running && !hold_done |-> !rel_done)
		else $error("release expired while hold still running");

	a_release_space: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL6
		step_up |-> since_restart >= TMR_W'(HOLD_CYCLES + RELEASE_CYCLES))
		else $error("gain raised before hold and release ended");

	a_shutdown_clear: assert property (@(posedge clk_in) disable iff (!arst_n_in) // RL11
		running |-> !shutdown_out)
		else $error("shutdown flag set while running");

endmodule // agx_core

// ===== agx_pkg.sv
// shared constants, types and helper functions of the audio gain compressor
package agx_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int ATTACK_TIME_US = 6400; // 6.4 ms per step
	localparam int RELEASE_TIME_MS = 1810; // 1.81 s per step
	localparam int HOLD_TIME_US = 1000; // pause after a gain change before release counts
	localparam int ATTACK_CYC = ATTACK_TIME_US * CYC_PER_US;
	localparam int RELEASE_CYC = RELEASE_TIME_MS * 1000 * CYC_PER_US;
	localparam int HOLD_CYC = HOLD_TIME_US * CYC_PER_US;

	// ----------------------------------------------------------------
	// gain scale: one code is one 0.5 dB step
	// ----------------------------------------------------------------
	localparam int GAIN_W = 7;
	localparam int ENV_W = 8;
	localparam int LVL_W = 9;
	localparam logic [GAIN_W-1:0] GAIN_STEP = 7'h01;
	localparam int FIXED_GAIN_DB = 6;
	localparam int MAX_GAIN_DB = 30;
	localparam logic [GAIN_W-1:0] FIXED_GAIN_CODE = GAIN_W'(FIXED_GAIN_DB * 2);
	localparam logic [GAIN_W-1:0] MAX_GAIN_CODE = GAIN_W'(MAX_GAIN_DB * 2);

	// ----------------------------------------------------------------
	// level scale: envelope code 0 is the floor, one code is 0.5 dB
	// ----------------------------------------------------------------
	localparam int ENV_FLOOR_DBV = -64;
	localparam int LIMIT_DBV = 9;
	localparam int NGATE_MV = 20;
	localparam int NGATE_DBV = -34; // 20 mV rounded to whole dBV
	localparam int COMP_RATIO = 2; // 2:1
	localparam logic [LVL_W-1:0] LIMIT_CODE = LVL_W'((LIMIT_DBV - ENV_FLOOR_DBV) * 2);
	localparam logic [ENV_W-1:0] NGATE_CODE = ENV_W'((NGATE_DBV - ENV_FLOOR_DBV) * 2);
	localparam logic [LVL_W-1:0] COMP_OFFSET = LVL_W'(LIMIT_CODE - LIMIT_CODE / COMP_RATIO);
	localparam logic [LVL_W-1:0] STEADY_BAND = 9'h002; // 1 dB window under the target
	localparam int TEMP_W = 9;
	localparam logic [TEMP_W-1:0] TEMP_LIMIT_C = 9'h096; // 150 degrees C

	// ----------------------------------------------------------------
	// function sets and control states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {MODE_OFF, MODE_LIMIT, MODE_COMP, MODE_GATE} agx_mode_t;
	typedef enum logic [1:0] {ST_OFF, ST_HOT, ST_RUN} agx_state_t;

	// output level seen at the speaker in level codes
	function automatic logic [LVL_W-1:0] agx_out_level(input logic [ENV_W-1:0] env,
			input logic [GAIN_W-1:0] gain);
		agx_out_level = {1'b0, env} + {2'b00, gain};
	endfunction

	// wanted output level: limiter ceiling, or a 2:1 curve when compressing
	function automatic logic [LVL_W-1:0] agx_target(input agx_mode_t mode,
			input logic [ENV_W-1:0] env);
		if (mode == MODE_LIMIT) begin
			agx_target = LIMIT_CODE;
		end else begin
			agx_target = LVL_W'({1'b0, env} / COMP_RATIO) + COMP_OFFSET;
		end
	endfunction

endpackage

// ===== agx_timer.sv
// restartable down counter used for the attack, release and hold timers
`timescale 1ns/10ps
module agx_timer import agx_pkg::*; #(
	parameter int W = 28,
	parameter int LOAD = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// control
	input wire logic restart_in,
	input wire logic run_in,
	// status
	output logic expired_out
);

	logic [W-1:0] cnt;

	// restart reloads the full period; counting stops at zero
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt <= '0;
		end else if (restart_in) begin
			cnt <= W'(LOAD);
		end else if (run_in && cnt != '0) begin
			cnt <= cnt - W'(1);
		end
	end

	assign expired_out = (cnt == '0);

	// expiry is reached only by counting down from one
	a_timer_expiry: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(expired_out) |-> $past(cnt) == W'(1)) // RL9
		else $error("timer expired without counting down");

endmodule // agx_timer

// ===== agx_level.sv
// compares the envelope and the current gain against limiter, target and gate
`timescale 1ns/10ps
module agx_level import agx_pkg::*; (
	// inputs
	input wire logic [ENV_W-1:0] env_in,
	input wire logic [GAIN_W-1:0] gain_in,
	input wire agx_mode_t mode_in,
	// decisions
	output logic above_limit_out,
	output logic below_target_out,
	output logic gate_closed_out
);

	logic [LVL_W-1:0] out_level;
	logic [LVL_W-1:0] target;
	logic [LVL_W:0] lifted;

	// levels in one scale so a gain step moves the output by one code
	assign out_level = agx_out_level(env_in, gain_in);
	assign target = agx_target(mode_in, env_in);
	assign lifted = {1'b0, out_level} + {1'b0, STEADY_BAND};

	// the steady window keeps a near-constant signal from hunting
	assign above_limit_out = (out_level > LIMIT_CODE); // RL10
	assign below_target_out = (lifted < {1'b0, target}); // RL2
	assign gate_closed_out = (mode_in == MODE_GATE) && (env_in < NGATE_CODE); // RL12

endmodule // agx_level

// ===== agx_src.sv
// audio source and static select pins facing the gain compressor
`timescale 1ns/10ps
module agx_src import agx_pkg::*; (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// wanted setting from the bench
	input wire logic [1:0] mode_in,
	input wire logic [ENV_W-1:0] env_in,
	// pins toward the device
	output logic function_select_high_out,
	output logic function_select_low_out,
	output logic [ENV_W-1:0] envelope_out
);
	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	// pins move only on a clock edge, so a mode change never lands mid-cycle
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			function_select_high_out <= 1'b0;
			function_select_low_out <= 1'b0;
			envelope_out <= 8'h00;
		end else begin
			function_select_high_out <= mode_in[1];
			function_select_low_out <= mode_in[0];
			envelope_out <= env_in;
		end
	end
endmodule // agx_src

// ===== agx_core_test.sv
// self-checking testbench of the gain compressor core
`timescale 1ns/10ps
module agx_core_test import agx_pkg::*;;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int A = 8;
	localparam int R = 16;
	localparam int H = 2;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [1:0] want_mode = 2'h0;
	logic [ENV_W-1:0] want_env = 8'h00;
	logic [TEMP_W-1:0] temp = 9'h019;
	wire logic sel_hi;
	wire logic sel_lo;
	wire logic [ENV_W-1:0] env;
	wire logic [GAIN_W-1:0] gain_out;
	wire logic shutdown_out;
	wire logic limiting_out;
	wire logic gate_closed_out;
	wire logic attack_busy_out;
	int err_count = 0;
	int comparisons = 0;

	// short timers keep the run small; all expectations use them
	always #5 clk_in = ~clk_in;

	agx_src i_src (.clk_in(clk_in), .arst_n_in(arst_n_in), .mode_in(want_mode),
		.env_in(want_env), .function_select_high_out(sel_hi),
		.function_select_low_out(sel_lo), .envelope_out(env));

	agx_core #(.ATTACK_CYCLES(A), .RELEASE_CYCLES(R), .HOLD_CYCLES(H)) i_dut (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .function_select_high_in(sel_hi),
		.function_select_low_in(sel_lo), .envelope_in(env), .junction_temp_in(temp),
		.gain_out(gain_out), .shutdown_out(shutdown_out), .limiting_out(limiting_out),
		.gate_closed_out(gate_closed_out), .attack_busy_out(attack_busy_out));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// settled gain under the limiter ceiling
	function automatic int lim_gain(input int e);
		return int'(LIMIT_CODE) - e;
	endfunction

	// settled gain on the compression curve, clipped to the maximum gain of 60
	function automatic int comp_gain(input int e);
		int g;
		g = e / COMP_RATIO + int'(COMP_OFFSET) - int'(STEADY_BAND) - e;
		return (g > 60) ? 60 : g;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %0d seen %0d", name, exp, seen);
		end
	endtask

	task automatic drive(input logic [1:0] m, input logic [ENV_W-1:0] e);
		@(posedge clk_in);
		want_mode <= m;
		want_env <= e;
	endtask

	task automatic set_temp(input logic [TEMP_W-1:0] t);
		@(posedge clk_in);
		temp <= t;
		repeat (3) @(negedge clk_in);
	endtask

	// waits for the next gain change, at most lim cycles; sampled at falling edges
	task automatic wait_step(input int lim, output int n, output logic [GAIN_W-1:0] g);
		logic [GAIN_W-1:0] g0;
		g0 = gain_out;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (gain_out === g0 && n < lim);
		g = gain_out;
	endtask

	// waits until the gain has been still for 40 cycles
	task automatic settle();
		int n;
		logic [GAIN_W-1:0] g;
		for (int i = 0; i < 60; i++) begin
			wait_step(40, n, g);
			if (n == 40) break;
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	// the whole sequence needs under 6000 cycles; the guard allows far more
	initial begin
		#300us;
		err_count++;
		$display("[FAIL] watchdog expected finish seen timeout");
		give_verdict();
	end

	initial begin
		int n;
		int e;
		int t;
		logic [GAIN_W-1:0] g;
		logic [GAIN_W-1:0] gp;
		e = $urandom(86);
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'b1;
		@(negedge clk_in);
		check("gain_reset", gain_out, FIXED_GAIN_CODE);
		check("shutdown_reset", shutdown_out, 0);
		// quiet input under the limiter: release steps up to the maximum
		drive(2'b01, 8'h32);
		wait_step(100, n, g);
		check("rise_first", g, 13);
		for (int i = 14; i <= 60; i++) begin
			wait_step(100, n, g);
			check("rise_step", g, i);
			check("rise_period", n, H + R + 1);
		end
		wait_step(100, n, g);
		check("max_hold", n, 100);
		$display("test rise done");
		// loud input: instant cut, then one step per attack period
		e = 90 + $urandom % 20;
		drive(2'b01, e[7:0]);
		wait_step(5, n, g);
		check("cut_now", g, 59);
		check("attack_busy", attack_busy_out, 1);
		check("limiting", limiting_out, 1);
		while (g > lim_gain(e) && n < 50) begin
			gp = g;
			wait_step(50, n, g);
			check("cut_period", n, A + 1);
			check("cut_step", g, gp - 1);
		end
		wait_step(300, n, g);
		check("steady_time", n, 300);
		check("steady_gain", g, lim_gain(e));
		$display("test limiter done");
		// compression curve
		drive(2'b10, 8'h1e);
		settle();
		check("comp_gain", gain_out, comp_gain(30));
		$display("test compression done");
		// thermal trip, its boundary, then random temperatures
		set_temp(9'h097);
		check("hot_shutdown", shutdown_out, 1);
		check("hot_gain", gain_out, FIXED_GAIN_CODE);
		set_temp(9'h096);
		check("edge_shutdown", shutdown_out, 0);
		for (int i = 0; i < 16; i++) begin
			t = 140 + $urandom % 20;
			set_temp(t[8:0]);
			check("rand_shutdown", shutdown_out, t > 150);
		end
		set_temp(9'h019);
		$display("test thermal done");
		// closed gate blocks rises that compression alone would make
		drive(2'b11, 8'h14);
		repeat (4) @(negedge clk_in);
		check("gate_closed", gate_closed_out, 1);
		wait_step(200, n, g);
		check("gate_hold", n, 200);
		drive(2'b10, 8'h14);
		wait_step(40, n, g);
		check("gate_open_rise", g, 13);
		check("gate_open", gate_closed_out, 0);
		$display("test gate done");
		// function off forces fixed gain and stays there
		drive(2'b00, 8'h80);
		repeat (5) @(negedge clk_in);
		check("off_gain", gain_out, FIXED_GAIN_CODE);
		wait_step(100, n, g);
		check("off_hold", n, 100);
		$display("test off done");
		give_verdict();
	end
endmodule // agx_core_test
